// ==== src/cdc_helpers.sv ====
// Bit and word synchronizers joining a slow source link to the local clock
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps

// Behaviour
// - Single-bit path offers extra output flop parameter, default true.
// - All bits of a delivered word appear in one destination cycle.
// - Source-side reset clears the destination word to zero.
// - Valid with ready high captures the word; valid ignored while ready low.
// - Source ready high only when a new word can be accepted.
// - Source acknowledge asserts once the word reached the destination domain.
// - Delivered word driven on destination output with a valid pulse.
// - The block only answers register accesses; it never starts one.
module cdc_helpers
  import cdc_helpers_pkg::*;
#(
  parameter int DATA_W = DEFAULT_DATA_W,
  parameter int FIFO_DEPTH = DEFAULT_FIFO_DEPTH,
  parameter bit ENABLE_OUTPUT_REGISTER = DEFAULT_OUT_REG
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // Single-bit crossing
  input wire logic i_bit,
  output logic o_bit,
  // Source side of the word crossing, timed by the link clock
  input wire logic i_src_clk,
  input wire logic i_src_rst,
  input wire logic i_src_valid,
  input wire logic [DATA_W-1:0] i_src_data,
  output logic o_src_ready,
  output logic o_src_ack,
  // Destination side of the word crossing
  input wire logic i_dest_ready,
  output logic o_dest_valid,
  output logic [DATA_W-1:0] o_dest_data,
  // Register port
  input wire logic [REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [REG_DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [REG_DATA_W-1:0] o_reg_rdata
);

  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

  if (DATA_W < 1 || FIFO_DEPTH < 2) begin : g_bad_params
    $error("cdc_helpers needs DATA_W >= 1 and FIFO_DEPTH >= 2");
  end
  if (STAT_LEVEL_LSB + LVL_W > REG_DATA_W) begin : g_bad_level
    $error("cdc_helpers FIFO level does not fit the status register");
  end

  // Narrow a word to the register width, zero-filling the top
  function automatic logic [REG_DATA_W-1:0] to_reg(
    input logic [DATA_W-1:0] w
  );
    logic [REG_DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W && i < REG_DATA_W; i++) begin
      r[i] = w[i];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Single-bit crossing
  // ---------------------------------------------------------------
  logic [SYNC_STAGES-1:0] bit_sync_q;
  logic bit_out_q;

  // Plain flop chain: no logic may sit between the stages
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bit_sync_q <= '0;
    end else begin
      bit_sync_q <= {bit_sync_q[SYNC_STAGES-2:0], i_bit};
    end
  end

  // Extra flop lets synthesis replicate the driver for fanout
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bit_out_q <= 1'b0;
    end else begin
      bit_out_q <= bit_sync_q[SYNC_STAGES-1];
    end
  end

  assign o_bit = ENABLE_OUTPUT_REGISTER ? bit_out_q
                                        : bit_sync_q[SYNC_STAGES-1];

  // ---------------------------------------------------------------
  // Link-side inputs: two flops each before anything reads them
  // ---------------------------------------------------------------
  logic [SYNC_STAGES-1:0] sclk_sync_q;
  logic sclk_prev_q;
  logic [SYNC_STAGES-1:0] srst_sync_q;
  logic [SYNC_STAGES-1:0] svalid_sync_q;
  logic [DATA_W-1:0] sdata_s1_q;
  logic [DATA_W-1:0] sdata_s2_q;
  logic src_rise;
  logic src_fall;
  logic src_rst_s;
  logic src_valid_s;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sclk_sync_q <= '0;
      sclk_prev_q <= 1'b0;
      srst_sync_q <= '0;
      svalid_sync_q <= '0;
      sdata_s1_q <= '0;
      sdata_s2_q <= '0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[SYNC_STAGES-2:0], i_src_clk};
      sclk_prev_q <= sclk_sync_q[SYNC_STAGES-1];
      srst_sync_q <= {srst_sync_q[SYNC_STAGES-2:0], i_src_rst};
      svalid_sync_q <= {svalid_sync_q[SYNC_STAGES-2:0], i_src_valid};
      sdata_s1_q <= i_src_data;
      sdata_s2_q <= sdata_s1_q;
    end
  end

  assign src_rise = sclk_sync_q[SYNC_STAGES-1] && !sclk_prev_q;
  assign src_fall = !sclk_sync_q[SYNC_STAGES-1] && sclk_prev_q;
  assign src_rst_s = srst_sync_q[SYNC_STAGES-1];
  assign src_valid_s = svalid_sync_q[SYNC_STAGES-1];

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic drain_en_q;
  logic flush_q;
  logic [REG_DATA_W-1:0] count_q;
  logic [DATA_W-1:0] last_q;
  logic [REG_DATA_W-1:0] rdata_q;

  // ---------------------------------------------------------------
  // Word capture on the link side
  // ---------------------------------------------------------------
  xfer_state_t state_q;
  logic [DATA_W-1:0] word_q;
  logic ready_q;
  logic ack_q;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [DATA_W-1:0] fifo_out_data;
  logic [LVL_W-1:0] fifo_level;
  logic fifo_flush;

  assign fifo_in_valid = (state_q == XFER_PUSH);
  assign fifo_flush = src_rst_s || flush_q;

  // Link data is sampled at its falling edge, half a period after it moved
  always_ff @(posedge i_clk) begin
    if (i_rst || src_rst_s) begin
      state_q <= XFER_IDLE;
      word_q <= '0;
    end else begin
      unique case (state_q)
        XFER_IDLE: begin
          if (src_fall && ready_q && src_valid_s) begin
            word_q <= sdata_s2_q;
            state_q <= XFER_PUSH;
          end
        end
        XFER_PUSH: begin
          // A full FIFO stalls the capture until the drain side moves
          if (fifo_in_ready) begin
            state_q <= XFER_ACK;
          end
        end
        XFER_ACK: begin
          if (src_rise) begin
            state_q <= XFER_IDLE;
          end
        end
      endcase
    end
  end

  // Link-facing outputs move just after link rising edges; ready also drops
  // at capture and stays low while ack stands, so a held word is not retaken
  always_ff @(posedge i_clk) begin
    if (i_rst || src_rst_s) begin
      ready_q <= 1'b0;
    end else if (state_q == XFER_IDLE && src_fall && ready_q &&
                 src_valid_s) begin
      ready_q <= 1'b0;
    end else if (src_rise) begin
      ready_q <= (state_q == XFER_IDLE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || src_rst_s) begin
      ack_q <= 1'b0;
    end else if (src_rise) begin
      ack_q <= (state_q == XFER_ACK);
    end
  end

  assign o_src_ready = ready_q;
  assign o_src_ack = ack_q;

  // ---------------------------------------------------------------
  // Buffer between capture and delivery
  // ---------------------------------------------------------------
  word_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_flush(fifo_flush),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(word_q),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data),
    .o_level(fifo_level)
  );

  assign fifo_out_ready = drain_en_q && i_dest_ready;

  // ---------------------------------------------------------------
  // Destination delivery
  // ---------------------------------------------------------------
  logic dvalid_q;
  logic [DATA_W-1:0] ddata_q;

  // The whole word is loaded in one edge, so no mix of old and new bits
  always_ff @(posedge i_clk) begin
    if (i_rst || src_rst_s) begin
      dvalid_q <= 1'b0;
      ddata_q <= '0;
    end else begin
      dvalid_q <= fifo_out_valid && fifo_out_ready;
      if (fifo_out_valid && fifo_out_ready) begin
        ddata_q <= fifo_out_data;
      end
    end
  end

  assign o_dest_valid = dvalid_q;
  assign o_dest_data = ddata_q;

  // ---------------------------------------------------------------
  // Register port: a pure slave, answering only what it is asked
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      drain_en_q <= CTRL_DRAIN_EN_RESET;
      flush_q <= 1'b0;
    end else begin
      flush_q <= 1'b0;
      if (i_reg_wr && i_reg_addr == CTRL_OFFSET) begin
        drain_en_q <= i_reg_wdata[CTRL_DRAIN_EN_BIT];
        flush_q <= i_reg_wdata[CTRL_FLUSH_BIT];
      end
    end
  end

  // Delivered-word counter wraps; writing any value clears it unless a delivery counts in that cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_q <= '0;
    end else if (dvalid_q) begin
      count_q <= count_q + 1'b1;
    end else if (i_reg_wr && i_reg_addr == COUNT_OFFSET) begin
      count_q <= '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_q <= '0;
    end else if (dvalid_q) begin
      last_q <= ddata_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (i_reg_rd) begin
      rdata_q <= '0;
      unique case (i_reg_addr)
        CTRL_OFFSET: begin
          rdata_q[CTRL_DRAIN_EN_BIT] <= drain_en_q;
        end
        STATUS_OFFSET: begin
          rdata_q[STAT_READY_BIT] <= ready_q;
          rdata_q[STAT_EMPTY_BIT] <= (fifo_level == '0);
          rdata_q[STAT_FULL_BIT] <= !fifo_in_ready;
          rdata_q[STAT_BUSY_BIT] <= (state_q != XFER_IDLE);
          rdata_q[STAT_BIT_OUT_BIT] <= bit_out_q;
          rdata_q[STAT_LEVEL_LSB +: LVL_W] <= fifo_level;
        end
        COUNT_OFFSET: begin
          rdata_q <= count_q;
        end
        LAST_OFFSET: begin
          rdata_q <= to_reg(last_q);
        end
        default: begin
          rdata_q <= '0;
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_reg_rdata = rdata_q;

endmodule

// ==== src/cdc_helpers_pkg.sv ====
// Shared constants for the control-to-data crossing helpers
package cdc_helpers_pkg;

  // Register port geometry
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET = 8'h08;
  localparam logic [7:0] LAST_OFFSET = 8'h0c;

  // Control register fields
  localparam int CTRL_DRAIN_EN_BIT = 0;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam logic CTRL_DRAIN_EN_RESET = 1'b1;

  // Status register fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_EMPTY_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_BIT_OUT_BIT = 4;
  localparam int STAT_LEVEL_LSB = 8;

  // Crossing defaults
  localparam int SYNC_STAGES = 2;
  localparam int DEFAULT_DATA_W = 32;
  localparam int DEFAULT_FIFO_DEPTH = 16;
  localparam bit DEFAULT_OUT_REG = 1'b1;

  // Word transfer states
  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_PUSH,
    XFER_ACK
  } xfer_state_t;

endpackage

// ==== src/word_fifo.sv ====
// Synchronous FIFO with registered read data and valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_level
);

  localparam int AW = $clog2(DEPTH);

  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_params
    $error("word_fifo needs WIDTH >= 1 and DEPTH a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign count = wr_ptr_q - rd_ptr_q;
  assign o_in_ready = (o_level != (AW+1)'(DEPTH));
  assign push = i_in_valid && o_in_ready;
  // Refill the output register whenever it is empty or being taken
  assign pop = (count != '0) && (!o_out_valid || i_out_ready);
  // Level counts the output register too, so full means DEPTH words held
  assign o_level = count + {{AW{1'b0}}, o_out_valid};

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_flush) begin
      o_out_valid <= 1'b0;
      o_out_data <= '0;
    end else if (pop) begin
      o_out_valid <= 1'b1;
      o_out_data <= mem_q[rd_ptr_q[AW-1:0]];
    end else if (i_out_ready) begin
      o_out_valid <= 1'b0;
    end
  end

endmodule

// ==== bench/cdc_helpers_checker.sv ====
// Port-level assertions for the crossing helpers
`timescale 1ns/100ps
module cdc_helpers_checker
  import cdc_helpers_pkg::*;
#(
  parameter int DATA_W = DEFAULT_DATA_W,
  parameter int FIFO_DEPTH = DEFAULT_FIFO_DEPTH,
  parameter bit ENABLE_OUTPUT_REGISTER = DEFAULT_OUT_REG
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_bit,
  input wire logic o_bit,
  input wire logic i_src_clk,
  input wire logic i_src_rst,
  input wire logic i_src_valid,
  input wire logic [DATA_W-1:0] i_src_data,
  input wire logic o_src_ready,
  input wire logic o_src_ack,
  input wire logic i_dest_ready,
  input wire logic o_dest_valid,
  input wire logic [DATA_W-1:0] o_dest_data,
  input wire logic [REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [REG_DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [REG_DATA_W-1:0] o_reg_rdata
);
  logic [1:0] up_q;
  // History before reset release is not judged for the bit delay
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  bit_delay_a: assert property (up_q == 2'h3 |-> o_bit ==
    (ENABLE_OUTPUT_REGISTER ? $past(i_bit, 3) : $past(i_bit, 2)))
    else $error("single bit delay wrong");
  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == '0)
    else $error("read data without a read");
  word_whole_a: assert property ($changed(o_dest_data) |->
    o_dest_valid || o_dest_data == '0) else $error("word changed silently");
  dvalid_cause_a: assert property (o_dest_valid |-> $past(i_dest_ready))
    else $error("delivery without consumer ready");
  srst_clear_a: assert property (i_src_rst [*4] |->
    o_dest_data == '0 && !o_src_ready) else $error("source reset ignored");
  ready_fall_a: assert property ($fell(o_src_ready) |->
    i_src_valid || i_src_rst) else $error("ready fell without a word");
  ack_ready_a: assert property ($rose(o_src_ack) |->
    !o_src_ready && i_src_valid) else $error("ack out of place");
  ack_excl_a: assert property (!(o_src_ack && o_src_ready))
    else $error("ready high while ack stands");
  ack_hold_a: assert property ($rose(o_src_ack) |=> o_src_ack [*8])
    else $error("ack too short");
endmodule

bind cdc_helpers cdc_helpers_checker #(.DATA_W(DATA_W),
  .FIFO_DEPTH(FIFO_DEPTH), .ENABLE_OUTPUT_REGISTER(ENABLE_OUTPUT_REGISTER))
  checker_inst (.i_clk(i_clk), .i_rst(i_rst), .i_bit(i_bit), .o_bit(o_bit),
  .i_src_clk(i_src_clk), .i_src_rst(i_src_rst), .i_src_valid(i_src_valid),
  .i_src_data(i_src_data), .o_src_ready(o_src_ready),
  .o_src_ack(o_src_ack), .i_dest_ready(i_dest_ready),
  .o_dest_valid(o_dest_valid), .o_dest_data(o_dest_data),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

// ==== bench/link_source.sv ====
// Source-side model that offers words on the slow link
`timescale 1ns/100ps
module link_source #(
  parameter int W = 32,
  parameter int HALF_NS = 40
) (
  output logic o_link_clk,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ack
);
  initial begin
    o_link_clk = 1'b0;
    o_valid = 1'b0;
    o_data = '0;
  end
  // Clock stands low between calls; a refused word stays held for the next
  task automatic send(input logic [W-1:0] w, input int max_cyc,
    output bit ok);
    ok = 1'b0;
    #1;
    for (int n = 0; n < max_cyc && !ok; n++) begin
      o_link_clk = 1'b1;
      if (o_valid && i_ack === 1'b1) begin
        ok = 1'b1;
        o_valid = 1'b0;
        o_data = ~o_data;
      end else begin
        o_valid = 1'b1;
        o_data = w;
      end
      #(HALF_NS) o_link_clk = 1'b0;
      #(HALF_NS);
    end
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the crossing helpers
`timescale 1ns/100ps
module testbench
  import cdc_helpers_pkg::*;
;
  logic i_clk, i_rst, i_bit, i_src_rst, i_dest_ready, i_reg_wr, i_reg_rd;
  logic i_src_clk, i_src_valid, o_bit, o_src_ready, o_src_ack, o_dest_valid;
  logic hold;
  logic [31:0] i_src_data, o_dest_data, i_reg_wdata, o_reg_rdata;
  logic [31:0] seed, rseed, d;
  logic [7:0] i_reg_addr;
  logic [31:0] exp_q[$];
  int fail_count, n_compared, cyc;
  bit ok;

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  cdc_helpers cdc_helpers_inst (.i_clk(i_clk), .i_rst(i_rst), .i_bit(i_bit),
    .o_bit(o_bit), .i_src_clk(i_src_clk), .i_src_rst(i_src_rst),
    .i_src_valid(i_src_valid), .i_src_data(i_src_data),
    .o_src_ready(o_src_ready), .o_src_ack(o_src_ack),
    .i_dest_ready(i_dest_ready), .o_dest_valid(o_dest_valid),
    .o_dest_data(o_dest_data), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata));
  link_source link_source_inst (.o_link_clk(i_src_clk),
    .o_valid(i_src_valid), .o_data(i_src_data), .i_ack(o_src_ack));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= v;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 v = o_reg_rdata;
  endtask

  task automatic push_word(input int max_cyc);
    seed = lfsr(seed);
    exp_q.push_back(seed);
    link_source_inst.send(seed, max_cyc, ok);
  endtask

  task automatic wait_empty;
    for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge i_clk);
    check(32'(exp_q.size()), 32'h0);
  endtask

  // Random consumer stalls; deliveries are compared in order
  always @(posedge i_clk) begin
    rseed <= lfsr(rseed);
    i_dest_ready <= !hold && (rseed[3] | rseed[7]);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out;
    end else if (!i_rst && o_dest_valid === 1'b1) begin
      check(o_dest_data, exp_q.size() ? exp_q.pop_front() : 32'hx);
    end
  end

  initial begin
    {i_rst, hold} = 2'h3;
    {i_bit, i_src_rst, i_dest_ready, i_reg_wr, i_reg_rd} = 5'h0;
    i_reg_addr = 8'h0;
    i_reg_wdata = 32'h0;
    {fail_count, n_compared, cyc} = {32'h0, 32'h0, 32'h0};
    seed = 32'h4bb1;
    rseed = lfsr(32'h4bb1);
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    hold <= 1'b0;
    reg_rd(CTRL_OFFSET, d);
    check(d, 32'h1);
    reg_wr(8'h40, 32'hffff);
    reg_rd(8'h40, d);
    check(d, 32'h0);
    reg_rd(STATUS_OFFSET, d);
    check(d & 32'h6, 32'h2);
    $display("Test reset values done");
    for (int k = 0; k < 8; k++) begin
      push_word(40);
      check({31'h0, ok}, 32'h1);
    end
    wait_empty;
    reg_rd(COUNT_OFFSET, d);
    check(d, 32'h8);
    reg_rd(LAST_OFFSET, d);
    check(d, seed);
    $display("Test random words done");
    reg_wr(CTRL_OFFSET, 32'h0);
    for (int k = 0; k < 16; k++) begin
      push_word(40);
      check({31'h0, ok}, 32'h1);
    end
    reg_rd(STATUS_OFFSET, d);
    check(d & 32'h1f04, 32'h1004);
    push_word(8);
    check({31'h0, ok}, 32'h0);
    hold <= 1'b1;
    reg_wr(CTRL_OFFSET, 32'h1);
    repeat (50) @(posedge i_clk);
    check(32'(exp_q.size()), 32'h11);
    hold <= 1'b0;
    link_source_inst.send(seed, 40, ok);
    check({31'h0, ok}, 32'h1);
    wait_empty;
    reg_rd(COUNT_OFFSET, d);
    check(d, 32'h19);
    reg_wr(COUNT_OFFSET, 32'h0);
    reg_rd(COUNT_OFFSET, d);
    check(d, 32'h0);
    $display("Test fill and drain done");
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      @(posedge i_clk);
      i_bit <= seed[0];
      repeat (3) @(posedge i_clk);
      #1 check({31'h0, o_bit}, {31'h0, seed[0]});
    end
    $display("Test single bit done");
    // Pulsed on purpose; in a system it stays off the global reset
    @(posedge i_clk);
    i_src_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    #1 check(o_dest_data, 32'h0);
    @(posedge i_clk);
    i_src_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    push_word(40);
    check({31'h0, ok}, 32'h1);
    wait_empty;
    $display("Test source reset done");
    close_out;
  end
endmodule
